// ### plp_pkg.sv
/*
  Constants, register map, reset values, timing counts and carrier types for the
  protected configuration and converter readback registers.
  Assumes a 40 MHz core clock and a register front end that hands over
  whole-byte register reads and writes.
*/
// What this block does
// - The input-voltage reading is 8 bits, resets to zero and holds still while the capacitor test enable is set.
// - The input-current reading is 8 bits and holds still while the capacitor test enable is set.
// - Input current in milliamps is the current code times an LSB weight picked by the 3-bit current limit select.
// - The LSB weights for limit codes 0 to 7 are 8, 13.33, 16.67, 20, 23.33, 26.67, 30 and 40 mA.
// - Bit 4 of the input monitor control register enables the converter, resets to 1, and spares the storage channel.
// - Writing 0x56, 0xE3, 0x5A, 0xAC to 0xF0 and then reading 0xF0 unlocks, and that read returns 0x13.
// - Converter enable, limit-buck enable, release timer, exit threshold and open timer only change after unlock.
// - Limit-buck enable, reset 0, decides whether a tripped limit with the bus feedback at reference starts buck.
// - The 6-bit release timer, reset 010000, ends limit-buck operation at 0.1 ms for code 0 up to 6.4 ms.
// - Limit-buck release ends early once storage feedback falls below the 95/92.5/90/87.5 percent threshold.
// - The 4-bit open timer, reset 1111, counts 0.8 ms per code and flags the capacitor open if target comes first.
// - The capacitor health test starts on a rising edge of its enable.
package plp_pkg;
  localparam logic [7:0] ADDR_VIN = 8'h0D;
  localparam logic [7:0] ADDR_IIN = 8'h0E;
  localparam logic [7:0] ADDR_MON = 8'h0F;
  localparam logic [7:0] ADDR_LBEN = 8'h13;
  localparam logic [7:0] ADDR_LBREL = 8'h14;
  localparam logic [7:0] ADDR_OPEN = 8'h16;
  localparam logic [7:0] ADDR_KEY = 8'hF0;

  localparam logic [7:0] KEY_SEQ [4] = '{8'h56, 8'hE3, 8'h5A, 8'hAC};
  localparam logic [2:0] KEY_DONE = 3'h4;
  localparam logic [7:0] UNLOCKED_ID = 8'h13;
  localparam logic [7:0] READ_ZERO = 8'h00;

  localparam int ADC_EN_BIT = 4;
  localparam int LB_EN_BIT = 0;
  localparam int RLS_TIMER_LSB = 2;
  localparam int RLS_TIMER_MSB = 7;
  localparam int EXIT_THR_LSB = 0;
  localparam int EXIT_THR_MSB = 1;
  localparam int OPEN_TH_LSB = 0;
  localparam int OPEN_TH_MSB = 3;

  // Asynchronous analog comparator inputs
  localparam int PIN_TRIP = 0;
  localparam int PIN_BUS_REF = 1;
  localparam int PIN_EXIT = 2;
  localparam int PIN_CHG = 3;
  localparam int PIN_TGT = 4;
  localparam int PIN_W = 5;

  // Timing: step times in microseconds, clock in MHz
  localparam int CLK_MHZ = 40;
  localparam int RLS_STEP_US = 100;
  localparam int OPEN_STEP_US = 800;
  localparam int RLS_STEP_CYCLES = RLS_STEP_US * CLK_MHZ;
  localparam int OPEN_STEP_CYCLES = OPEN_STEP_US * CLK_MHZ;

  // Current LSB weight per limit code, in units of 10 uA
  localparam logic [11:0] CUR_LSB_10UA [8] = '{12'h320, 12'h535, 12'h683, 12'h7D0,
                                              12'h91D, 12'hA6B, 12'hBB8, 12'hFA0};

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic adc_enable;
    logic limit_buck_enable;
    logic [5:0] limit_buck_release_timer;
    logic [1:0] release_exit_threshold;
    logic [3:0] storage_open_timer_threshold;
  } cfg_s;

  localparam cfg_s CFG_RST = '{adc_enable: 1'b1, limit_buck_enable: 1'b0,
                               limit_buck_release_timer: 6'h10, release_exit_threshold: 2'h0,
                               storage_open_timer_threshold: 4'hF};

  typedef enum logic {LB_IDLE, LB_ACTIVE} lb_state_e;
endpackage

// ### key_unlock.sv
/*
  Password sequencer on the key register.
  Assumes one-cycle write and read pulses for the key address from the top.
*/
`timescale 1ns/1ps
`default_nettype none
module key_unlock (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Key register access
  input wire logic wr_key,
  input wire logic rd_key,
  input wire logic [7:0] key_data,
  // Result
  output logic unlocked,
  output logic [7:0] key_rdata
);
  typedef struct packed {
    logic [2:0] step;
    logic unlocked;
  } unlock_s;

  unlock_s r;
  unlock_s next_r;

  always_comb begin
    next_r = r;
    if (wr_key) begin
      // Any key write restarts the lock
      next_r.unlocked = 1'b0;
      if (r.step != plp_pkg::KEY_DONE && key_data == plp_pkg::KEY_SEQ[r.step[1:0]]) begin
        next_r.step = r.step + 3'h1;
      end else begin
        next_r.step = (key_data == plp_pkg::KEY_SEQ[0]) ? 3'h1 : 3'h0;
      end
    end else if (rd_key && r.step == plp_pkg::KEY_DONE) begin
      next_r.unlocked = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign unlocked = r.unlocked;
  assign key_rdata = (r.step == plp_pkg::KEY_DONE) ? plp_pkg::UNLOCKED_ID : plp_pkg::READ_ZERO;

  sequence s_key(logic [7:0] k);
    wr_key && key_data == k;
  endsequence

  property p_unlock;
    @(posedge clk) disable iff (rst)
      s_key(8'h56) ##1 s_key(8'hE3) ##1 s_key(8'h5A) ##1 s_key(8'hAC) ##1 rd_key |-> key_rdata == 8'h13 ##1 unlocked;
  endproperty

  AST_UNLOCK_SEQ: assert property (p_unlock) else $error("key sequence did not unlock");

  AST_KEY_WRITE_LOCKS: assert property (@(posedge clk) disable iff (rst)
    wr_key |=> !unlocked) else $error("key write left the lock open");
endmodule
`default_nettype wire

// ### limit_buck_ctrl.sv
/*
  Current-limit buck entry and release timing.
  Assumes synchronised comparator levels and a stable configuration.
*/
`timescale 1ns/1ps
`default_nettype none
module limit_buck_ctrl #(
  parameter int STEP_CYCLES = plp_pkg::RLS_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire logic enable,
  input wire logic [5:0] rls_code,
  // Conditions
  input wire logic tripped,
  input wire logic bus_at_ref,
  input wire logic strg_below_exit,
  // State
  output logic active
);
  typedef struct packed {
    plp_pkg::lb_state_e st;
    logic [15:0] pre;
    logic [5:0] steps;
    logic [5:0] code;
  } lb_s;

  lb_s r;
  lb_s next_r;
  logic [31:0] cyc;

  always_comb begin
    next_r = r;
    unique case (r.st)
      plp_pkg::LB_IDLE: begin
        if (enable && tripped && bus_at_ref) begin
          next_r.st = plp_pkg::LB_ACTIVE;
          next_r.pre = '0;
          next_r.steps = '0;
          next_r.code = rls_code;
        end
      end
      plp_pkg::LB_ACTIVE: begin
        if (strg_below_exit) begin
          next_r.st = plp_pkg::LB_IDLE;
        end else if (r.pre == 16'(STEP_CYCLES - 1)) begin
          next_r.pre = '0;
          next_r.steps = r.steps + 6'h01;
          if (r.steps == r.code) begin
            next_r.st = plp_pkg::LB_IDLE;
          end
        end else begin
          next_r.pre = r.pre + 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{st: plp_pkg::LB_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign active = (r.st == plp_pkg::LB_ACTIVE);

  // Cycles spent in the current release, for checking only
  always_ff @(posedge clk) begin
    if (rst || !active) begin
      cyc <= '0;
    end else begin
      cyc <= cyc + 32'h1;
    end
  end

  AST_LB_ENTER: assert property (@(posedge clk) disable iff (rst)
    !active && enable && tripped && bus_at_ref |=> active) else $error("limit buck not entered");

  AST_LB_OFF: assert property (@(posedge clk) disable iff (rst)
    !active && !enable |=> !active) else $error("limit buck entered while disabled");

  AST_LB_MAX_TIME: assert property (@(posedge clk) disable iff (rst)
    active |-> cyc < (32'(r.code) + 32'h1) * 32'(STEP_CYCLES)) else $error("release timer overrun");

  AST_LB_FULL_TIME: assert property (@(posedge clk) disable iff (rst)
    $fell(active) && !$past(strg_below_exit) |-> $past(cyc) == (32'($past(r.code)) + 32'h1) * 32'(STEP_CYCLES) - 32'h1)
    else $error("release ended before its time");

  AST_LB_EXIT: assert property (@(posedge clk) disable iff (rst)
    active && strg_below_exit |=> !active) else $error("exit threshold ignored");
endmodule
`default_nettype wire

// ### plp_cfg_regs.sv
/*
  Converter readback and password-protected configuration registers, with the
  limit-buck and storage open-timer logic they steer.
  Assumes a register front end on CLK giving one-cycle read and write pulses,
  converter samples on CLK, and asynchronous analog comparator levels.
*/
`timescale 1ns/1ps
`default_nettype none
module plp_cfg_regs #(
  parameter int RLS_STEP_CYCLES = plp_pkg::RLS_STEP_CYCLES,
  parameter int OPEN_STEP_CYCLES = plp_pkg::OPEN_STEP_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register access
  input wire plp_pkg::reg_req_s REG_REQ,
  output logic [7:0] REG_RDATA,
  // Converter samples
  input wire logic SAMPLE_VALID,
  input wire logic [7:0] INPUT_VOLTAGE_CODE,
  input wire logic [7:0] INPUT_CURRENT_CODE,
  // Settings held elsewhere
  input wire logic [2:0] INPUT_CURRENT_LIMIT_SEL,
  input wire logic CAP_HEALTH_TEST_ENABLE,
  // Analog comparators
  input wire logic [plp_pkg::PIN_W-1:0] ANALOG_PINS,
  // Controls and status
  output logic ADC_ENABLE,
  output logic CAP_TEST_START,
  output logic [19:0] INPUT_CURRENT_10UA,
  output logic LIMIT_BUCK_OPERATION,
  output logic [1:0] RELEASE_EXIT_THRESHOLD,
  output logic STORAGE_CAP_OPEN_FLAG,
  output logic UNLOCKED
);
  typedef struct packed {
    logic [plp_pkg::PIN_W-1:0] s1;
    logic [plp_pkg::PIN_W-1:0] s2;
    logic [plp_pkg::PIN_W-1:0] s3;
    logic [plp_pkg::PIN_W-1:0] filt;
    plp_pkg::cfg_s cfg;
    logic [7:0] input_voltage_reading;
    logic [7:0] input_current_reading;
    logic [7:0] rdata;
    logic [19:0] cur;
    logic cap_d;
    logic cap_start;
    logic chg_d;
    logic [15:0] open_pre;
    logic [3:0] open_steps;
    logic open_run;
    logic open_flag;
  } top_s;

  localparam top_s RST_VAL = '{cfg: plp_pkg::CFG_RST, default: '0};

  top_s r;
  top_s next_r;
  logic [7:0] key_rdata;
  logic lb_active;
  logic wr_ok;
  logic open_done;

  key_unlock u_key (
    .clk(CLK),
    .rst(RST),
    .wr_key(REG_REQ.write && REG_REQ.addr == plp_pkg::ADDR_KEY),
    .rd_key(REG_REQ.read && REG_REQ.addr == plp_pkg::ADDR_KEY),
    .key_data(REG_REQ.wdata),
    .unlocked(UNLOCKED),
    .key_rdata(key_rdata)
  );

  limit_buck_ctrl #(.STEP_CYCLES(RLS_STEP_CYCLES)) u_lb (
    .clk(CLK),
    .rst(RST),
    .enable(r.cfg.limit_buck_enable),
    .rls_code(r.cfg.limit_buck_release_timer),
    .tripped(r.filt[plp_pkg::PIN_TRIP]),
    .bus_at_ref(r.filt[plp_pkg::PIN_BUS_REF]),
    .strg_below_exit(r.filt[plp_pkg::PIN_EXIT]),
    .active(lb_active)
  );

  assign wr_ok = REG_REQ.write && UNLOCKED;
  assign open_done = (r.open_steps == r.cfg.storage_open_timer_threshold);

  always_comb begin
    next_r = r;
    // Three-stage synchroniser; a level counts once stages two and three agree
    next_r.s1 = ANALOG_PINS;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.filt = ((r.s2 ~^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.filt);

    // Converter readings frozen during the capacitor test
    if (SAMPLE_VALID && r.cfg.adc_enable && !CAP_HEALTH_TEST_ENABLE) begin
      next_r.input_voltage_reading = INPUT_VOLTAGE_CODE;
      next_r.input_current_reading = INPUT_CURRENT_CODE;
    end
    next_r.cur = r.input_current_reading * plp_pkg::CUR_LSB_10UA[INPUT_CURRENT_LIMIT_SEL];

    next_r.cap_d = CAP_HEALTH_TEST_ENABLE;
    next_r.cap_start = CAP_HEALTH_TEST_ENABLE && !r.cap_d;

    // Protected writes; reserved bits are not stored
    if (wr_ok) begin
      unique case (REG_REQ.addr)
        plp_pkg::ADDR_MON: begin
          next_r.cfg.adc_enable = REG_REQ.wdata[plp_pkg::ADC_EN_BIT];
        end
        plp_pkg::ADDR_LBEN: begin
          next_r.cfg.limit_buck_enable = REG_REQ.wdata[plp_pkg::LB_EN_BIT];
        end
        plp_pkg::ADDR_LBREL: begin
          next_r.cfg.limit_buck_release_timer = REG_REQ.wdata[plp_pkg::RLS_TIMER_MSB:plp_pkg::RLS_TIMER_LSB];
          next_r.cfg.release_exit_threshold = REG_REQ.wdata[plp_pkg::EXIT_THR_MSB:plp_pkg::EXIT_THR_LSB];
        end
        plp_pkg::ADDR_OPEN: begin
          next_r.cfg.storage_open_timer_threshold = REG_REQ.wdata[plp_pkg::OPEN_TH_MSB:plp_pkg::OPEN_TH_LSB];
        end
        default: begin
        end
      endcase
    end

    // Read data captured on the read pulse
    if (REG_REQ.read) begin
      unique case (REG_REQ.addr)
        plp_pkg::ADDR_VIN: next_r.rdata = r.input_voltage_reading;
        plp_pkg::ADDR_IIN: next_r.rdata = r.input_current_reading;
        plp_pkg::ADDR_MON: next_r.rdata = 8'(r.cfg.adc_enable) << plp_pkg::ADC_EN_BIT;
        plp_pkg::ADDR_LBEN: next_r.rdata = 8'(r.cfg.limit_buck_enable) << plp_pkg::LB_EN_BIT;
        plp_pkg::ADDR_LBREL: begin
          next_r.rdata = (8'(r.cfg.limit_buck_release_timer) << plp_pkg::RLS_TIMER_LSB)
                       | (8'(r.cfg.release_exit_threshold) << plp_pkg::EXIT_THR_LSB);
        end
        plp_pkg::ADDR_OPEN: begin
          next_r.rdata = 8'(r.cfg.storage_open_timer_threshold) << plp_pkg::OPEN_TH_LSB;
        end
        plp_pkg::ADDR_KEY: next_r.rdata = key_rdata;
        default: next_r.rdata = plp_pkg::READ_ZERO;
      endcase
    end

    // Storage open timer, started by each new charge
    next_r.chg_d = r.filt[plp_pkg::PIN_CHG];
    if (r.filt[plp_pkg::PIN_CHG] && !r.chg_d) begin
      next_r.open_run = 1'b1;
      next_r.open_flag = 1'b0;
      next_r.open_pre = '0;
      next_r.open_steps = '0;
    end else if (r.open_run) begin
      if (open_done) begin
        next_r.open_run = 1'b0;
      end else if (r.filt[plp_pkg::PIN_TGT]) begin
        next_r.open_run = 1'b0;
        next_r.open_flag = 1'b1;
      end else if (r.open_pre == 16'(OPEN_STEP_CYCLES - 1)) begin
        next_r.open_pre = '0;
        next_r.open_steps = r.open_steps + 4'h1;
      end else begin
        next_r.open_pre = r.open_pre + 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      r <= RST_VAL;
    end else begin
      r <= next_r;
    end
  end

  assign REG_RDATA = r.rdata;
  assign ADC_ENABLE = r.cfg.adc_enable;
  assign CAP_TEST_START = r.cap_start;
  assign INPUT_CURRENT_10UA = r.cur;
  assign LIMIT_BUCK_OPERATION = lb_active;
  assign RELEASE_EXIT_THRESHOLD = r.cfg.release_exit_threshold;
  assign STORAGE_CAP_OPEN_FLAG = r.open_flag;

  AST_VIN_HELD: assert property (@(posedge CLK) disable iff (RST)
    CAP_HEALTH_TEST_ENABLE |=> r.input_voltage_reading == $past(r.input_voltage_reading)) else $error("voltage reading moved in test");

  AST_VIN_TAKEN: assert property (@(posedge CLK) disable iff (RST)
    SAMPLE_VALID && ADC_ENABLE && !CAP_HEALTH_TEST_ENABLE ##1 REG_REQ.read && REG_REQ.addr == 8'h0D
    |=> REG_RDATA == $past(INPUT_VOLTAGE_CODE, 2)) else $error("voltage sample not read back");

  AST_IIN_HELD: assert property (@(posedge CLK) disable iff (RST)
    CAP_HEALTH_TEST_ENABLE |=> r.input_current_reading == $past(r.input_current_reading)) else $error("current reading moved in test");

  AST_CUR_40MA: assert property (@(posedge CLK) disable iff (RST)
    INPUT_CURRENT_LIMIT_SEL == 3'h7 |=> INPUT_CURRENT_10UA == 20'($past(r.input_current_reading)) * 20'd4000)
    else $error("wrong current scale at top code");

  AST_CUR_8MA: assert property (@(posedge CLK) disable iff (RST)
    INPUT_CURRENT_LIMIT_SEL == 3'h0 |=> INPUT_CURRENT_10UA == 20'($past(r.input_current_reading)) * 20'd800)
    else $error("wrong current scale at bottom code");

  AST_ADC_WRITE: assert property (@(posedge CLK) disable iff (RST)
    REG_REQ.write && UNLOCKED && REG_REQ.addr == 8'h0F |=> ADC_ENABLE == $past(REG_REQ.wdata[4]))
    else $error("converter enable not written");

  AST_LOCKED_KEEP: assert property (@(posedge CLK) disable iff (RST)
    !(REG_REQ.write && UNLOCKED) |=> r.cfg == $past(r.cfg)) else $error("locked field changed");

  AST_CAP_EDGE: assert property (@(posedge CLK) disable iff (RST)
    $rose(CAP_HEALTH_TEST_ENABLE) |=> CAP_TEST_START ##1 !CAP_TEST_START) else $error("test start pulse wrong");

  AST_OPEN_EARLY: assert property (@(posedge CLK) disable iff (RST)
    r.open_run && !open_done && r.filt[plp_pkg::PIN_TGT] && !(r.filt[plp_pkg::PIN_CHG] && !r.chg_d)
    |=> STORAGE_CAP_OPEN_FLAG && !r.open_run) else $error("open capacitor not flagged");
endmodule
`default_nettype wire

// ### plp_host.sv
/*
  Host-side model: issues single-byte register writes and reads and the key
  sequence, and notes the expected read data in a queue.
  Assumes the block samples requests on the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module plp_host (
  // Clock
  input wire logic clk,
  // Register access
  output var plp_pkg::reg_req_s req
);
  logic [7:0] exp_q[$];
  logic [7:0] key [4] = '{8'h56, 8'hE3, 8'h5A, 8'hAC};

  initial req = '0;

  // Reserved bits are always passed as zero, which is what they read back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(negedge clk);
    req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req <= '0;
  endtask

  // Keys go back to back with the read straight after, so the strobe is held across them
  task automatic unlock;
    exp_q.push_back(8'h13);
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      req <= '{write: 1'b1, read: 1'b0, addr: 8'hF0, wdata: key[k]};
    end
    @(negedge clk);
    req <= '{write: 1'b0, read: 1'b1, addr: 8'hF0, wdata: 8'h00};
    @(negedge clk);
    req <= '0;
  endtask
endmodule
`default_nettype wire

// ### plp_adc_and_protected_config_regs_tb.sv
/*
  Self-checking bench for the readback and protected configuration registers.
  Assumes shortened step counts of 4 and 8 cycles and the host model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin mismatches++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module plp_adc_and_protected_config_regs_tb;
  localparam int RLS = 4;
  localparam int OPN = 8;
  logic CLK, RST, SAMPLE_VALID, CAP_HEALTH_TEST_ENABLE, rd_d;
  logic [7:0] vcode, icode, rdata, e, v, i;
  logic [2:0] sel;
  logic [4:0] pins;
  logic adc_en, test_start, lb_op, open_flag, unl;
  logic [19:0] cur;
  logic [1:0] thr;
  plp_pkg::reg_req_s req;
  int mismatches, cmp_count, seed, n;
  logic [7:0] ra [7] = '{8'h0D, 8'h0E, 8'h0F, 8'h13, 8'h14, 8'h16, 8'h20};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h40, 8'h0F, 8'h00};
  logic [7:0] wm [7] = '{8'h00, 8'h00, 8'h10, 8'h01, 8'hFF, 8'h0F, 8'h00};
  logic [11:0] w [8] = '{12'h320, 12'h535, 12'h683, 12'h7D0, 12'h91D, 12'hA6B, 12'hBB8, 12'hFA0};

  plp_host i_plp_host (.clk(CLK), .req(req));

  plp_cfg_regs #(.RLS_STEP_CYCLES(RLS), .OPEN_STEP_CYCLES(OPN)) i_plp_cfg_regs (
    .CLK(CLK), .RST(RST), .REG_REQ(req), .REG_RDATA(rdata), .SAMPLE_VALID(SAMPLE_VALID),
    .INPUT_VOLTAGE_CODE(vcode), .INPUT_CURRENT_CODE(icode), .INPUT_CURRENT_LIMIT_SEL(sel),
    .CAP_HEALTH_TEST_ENABLE(CAP_HEALTH_TEST_ENABLE), .ANALOG_PINS(pins), .ADC_ENABLE(adc_en),
    .CAP_TEST_START(test_start), .INPUT_CURRENT_10UA(cur), .LIMIT_BUCK_OPERATION(lb_op),
    .RELEASE_EXIT_THRESHOLD(thr), .STORAGE_CAP_OPEN_FLAG(open_flag), .UNLOCKED(unl));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // Read results appear the cycle after the read edge
  always @(posedge CLK) rd_d <= req.read;
  always @(negedge CLK) begin
    if (rd_d) begin
      e = i_plp_host.exp_q.pop_front();
      `CHK("reg_rdata", e, rdata);
    end
  end

  task automatic conclude;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic hang;
    mismatches++;
    $display("[ERR] wait bound expired");
    conclude();
  endtask

  task automatic samp(input logic [7:0] a, input logic [7:0] b);
    @(negedge CLK);
    SAMPLE_VALID <= 1'b1;
    vcode <= a;
    icode <= b;
    @(negedge CLK);
    SAMPLE_VALID <= 1'b0;
  endtask

  task automatic lb_run(input logic [5:0] c, input bit early);
    int k;
    i_plp_host.wr(8'h14, {c, 2'b00});
    @(negedge CLK);
    pins <= 5'h03;
    k = 0;
    while (lb_op !== 1'b1) begin
      k++;
      if (k > 20) hang();
      @(negedge CLK);
    end
    pins <= early ? 5'h04 : 5'h00;
    k = 0;
    do begin
      k++;
      @(negedge CLK);
    end while (lb_op === 1'b1 && k < 400);
    pins <= 5'h00;
    if (early) `CHK("early_exit", 1'b1, k <= 6);
    if (!early) `CHK("buck_cycles", (c + 1) * RLS, k);
    repeat (6) @(negedge CLK);
    $display("done: limit buck code %0d", c);
  endtask

  initial begin
    repeat (20000) @(posedge CLK);
    hang();
  end

  initial begin
    seed = 32'hD1507869;
    RST = 1'b1;
    SAMPLE_VALID = 1'b0;
    CAP_HEALTH_TEST_ENABLE = 1'b0;
    vcode = 8'h00;
    icode = 8'h00;
    sel = 3'h0;
    pins = 5'h00;
    repeat (2) @(negedge CLK);
    RST <= 1'b0;
    for (int k = 0; k < 7; k++) i_plp_host.rd(ra[k], rv[k]);
    `CHK("adc_enable", 1'b1, adc_en);
    for (int k = 2; k < 6; k++) i_plp_host.wr(ra[k], rv[k] ^ wm[k]);
    for (int k = 2; k < 6; k++) i_plp_host.rd(ra[k], rv[k]);
    `CHK("adc_locked", 1'b1, adc_en);
    $display("done: reset values and locked writes");
    i_plp_host.wr(8'hF0, 8'h56);
    i_plp_host.wr(8'hF0, 8'h00);
    i_plp_host.rd(8'hF0, 8'h00);
    `CHK("unlocked_early", 1'b0, unl);
    i_plp_host.unlock();
    `CHK("unlocked", 1'b1, unl);
    for (int k = 2; k < 6; k++) i_plp_host.wr(ra[k], rv[k] ^ wm[k]);
    for (int k = 2; k < 6; k++) i_plp_host.rd(ra[k], rv[k] ^ wm[k]);
    `CHK("adc_off", 1'b0, adc_en);
    samp(8'($random(seed)), 8'($random(seed)));
    i_plp_host.rd(8'h0D, 8'h00);
    i_plp_host.wr(8'h0F, 8'h10);
    $display("done: unlock and protected writes");
    v = 8'($random(seed));
    i = 8'($random(seed));
    // Read lands the cycle right after the sample
    fork
      samp(v, i);
      begin
        @(negedge CLK);
        i_plp_host.rd(8'h0D, v);
      end
    join
    i_plp_host.rd(8'h0E, i);
    for (int s = 0; s < 8; s++) begin
      sel <= s[2:0];
      repeat (3) @(negedge CLK);
      `CHK("current_10ua", 20'(i) * 20'(w[s]), cur);
    end
    CAP_HEALTH_TEST_ENABLE <= 1'b1;
    n = 0;
    repeat (6) begin
      @(negedge CLK);
      if (test_start === 1'b1) n++;
    end
    `CHK("test_start_pulses", 1, n);
    samp(~v, ~i);
    i_plp_host.rd(8'h0D, v);
    i_plp_host.rd(8'h0E, i);
    CAP_HEALTH_TEST_ENABLE <= 1'b0;
    $display("done: converter readback");
    for (int t = 0; t < 4; t++) begin
      i_plp_host.wr(8'h14, {6'h05, t[1:0]});
      i_plp_host.rd(8'h14, {6'h05, t[1:0]});
      `CHK("exit_threshold", t[1:0], thr);
    end
    i_plp_host.wr(8'h13, 8'h00);
    pins <= 5'h03;
    repeat (10) @(negedge CLK);
    `CHK("buck_disabled", 1'b0, lb_op);
    pins <= 5'h00;
    repeat (5) @(negedge CLK);
    i_plp_host.wr(8'h13, 8'h01);
    lb_run(6'h01, 1'b0);
    lb_run(6'h05, 1'b0);
    lb_run(6'h3F, 1'b1);
    i_plp_host.wr(8'h16, 8'h03);
    pins <= 5'h08;
    repeat (6) @(negedge CLK);
    pins <= 5'h18;
    repeat (6) @(negedge CLK);
    `CHK("open_flag_set", 1'b1, open_flag);
    pins <= 5'h00;
    repeat (5) @(negedge CLK);
    pins <= 5'h08;
    repeat (6) @(negedge CLK);
    `CHK("open_flag_cleared", 1'b0, open_flag);
    repeat (30) @(negedge CLK);
    pins <= 5'h18;
    repeat (6) @(negedge CLK);
    `CHK("open_flag_late", 1'b0, open_flag);
    pins <= 5'h00;
    $display("done: open timer");
    repeat (4) @(negedge CLK);
    conclude();
  end
endmodule
`default_nettype wire
